// file: ifi_defs.svh
/*
 * constants of the input filter and interrupt unit: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz clock and synchronous, active-low reset.
 */
`ifndef IFI_DEFS_SVH
`define IFI_DEFS_SVH

`define IFI_CLK_MHZ        100
`define IFI_MS_CYCLES      (`IFI_CLK_MHZ * 1000)
// later words filter at about half the constant
`define IFI_LATE_DIV       2
// interrupt-path glitch filter: 0.1 ms, well inside 0.3 ms response
`define IFI_IRQ_FILT_US    100
`define IFI_IRQ_FILT_CYC   (`IFI_IRQ_FILT_US * `IFI_CLK_MHZ)

// register offsets (word index)
`define IFI_REG_CTRL       8'h00
`define IFI_REG_MODE       8'h01
`define IFI_REG_STATUS     8'h02
`define IFI_REG_CLEAR      8'h03
`define IFI_REG_ENABLE     8'h04
`define IFI_REG_QUICK      8'h05
`define IFI_REG_IN0        8'h06
`define IFI_REG_IN1        8'h07
`define IFI_REG_SETV0      8'h10
`define IFI_REG_CNT0       8'h14
`define IFI_REG_KNOB0      8'hfa
`define IFI_REG_KNOB1      8'hfb

// control fields
`define IFI_CTRL_TC_LSB    0
`define IFI_CTRL_BIG_BIT   4
`define IFI_CTRL_RESET     16'h0000

`define IFI_KNOB_MAX       8'hc8
`endif

// file: ifi_pkg.sv
/*
 * types of the input filter and interrupt unit.
 * assumes nothing beyond the constants header.
 */
package ifi_pkg;
   typedef enum logic {
      IFI_MODE_DIRECT,
      IFI_MODE_COUNT
   } ifi_mode_t;
   typedef logic [15:0] ifi_word_t;
endpackage

// file: ifi_unit.sv
/*
 * input conditioning for a small controller: debounce of two input
 * words, four interrupt inputs with direct or count mode, quick-response
 * pulse latches, and two knob words as BCD.
 * assumes synchronous field inputs, a scan pulse from the core, and a
 * plain register port with read data one cycle after the strobe.
 */
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "ifi_defs.svh"

module ifi_unit
   import ifi_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // field inputs and scan
   input  wire logic [11:0] in_word0,
   input  wire logic [11:0] in_word1,
   input  wire logic        scan_start,
   // knob samples, binary 0..255
   input  wire logic [7:0]  knob0_raw,
   input  wire logic [7:0]  knob1_raw,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // interrupt
   output logic             irq
);

   localparam int NIRQ = 4;

   // register file
   logic [15:0]     ctrl_q;
   logic [NIRQ-1:0] mode_q;
   logic [NIRQ-1:0] status_q;
   logic [NIRQ-1:0] enable_q;
   logic [NIRQ-1:0] quick_q;
   logic [15:0]     setv_q [NIRQ];
   logic [15:0]     cnt_q  [NIRQ];
   logic [15:0]     knob0_q;
   logic [15:0]     knob1_q;
   logic [7:0]      knob0_seen_q;
   logic [7:0]      knob1_seen_q;

   // debounce state
   logic [11:0] filt0_q;
   logic [11:0] filt1_q;
   logic [23:0] db0_cnt_q [12];
   logic [23:0] db1_cnt_q [12];
   logic [24:0] db_limit;
   logic [23:0] db_lim0;
   logic [23:0] db_lim1;

   // interrupt path state
   logic [NIRQ-1:0] ip_filt_q;
   logic [NIRQ-1:0] ip_prev_q;
   logic [13:0]     ip_cnt_q [NIRQ];
   logic [NIRQ-1:0] irq_event;
   logic [NIRQ-1:0] active_mask;
   logic [NIRQ-1:0] rise;
   logic            wr_clear;

   // debounce limit from the selected constant, 1 ms << code
   assign db_limit = 25'(`IFI_MS_CYCLES) << ctrl_q[`IFI_CTRL_TC_LSB +: 3];
   assign db_lim0  = 24'(db_limit);
   // later words settle faster, as the slow scan path does
   assign db_lim1  = 24'(db_limit / `IFI_LATE_DIV);

   // small variant exposes only bits 3 and 4
   assign active_mask = ctrl_q[`IFI_CTRL_BIG_BIT] ? 4'hf : 4'h3;
   assign rise        = ip_filt_q & ~ip_prev_q;
   assign wr_clear    = reg_wr && reg_addr == `IFI_REG_CLEAR;

   // per-bit debounce of both words; output follows after a stable run
   for (genvar b = 0; b < 12; b++) begin : g_db
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            db0_cnt_q[b] <= 24'h000000;
            db1_cnt_q[b] <= 24'h000000;
            filt0_q[b]   <= 1'b0;
            filt1_q[b]   <= 1'b0;
         end else begin
            // word 000: settles in limit cycles, total within +0.5 ms
            if (in_word0[b] == filt0_q[b]) begin
               db0_cnt_q[b] <= 24'h000000;
            end else if (db0_cnt_q[b] >= db_lim0 - 24'h000001) begin
               filt0_q[b]   <= in_word0[b];
               db0_cnt_q[b] <= 24'h000000;
            end else begin
               db0_cnt_q[b] <= db0_cnt_q[b] + 24'h000001;
            end
            if (in_word1[b] == filt1_q[b]) begin
               db1_cnt_q[b] <= 24'h000000;
            end else if (db1_cnt_q[b] >= db_lim1 - 24'h000001) begin
               filt1_q[b]   <= in_word1[b];
               db1_cnt_q[b] <= 24'h000000;
            end else begin
               db1_cnt_q[b] <= db1_cnt_q[b] + 24'h000001;
            end
         end
      end
   end

   // interrupt terminals 3..6: short filter, own edge, own counter
   for (genvar i = 0; i < NIRQ; i++) begin : g_irq
      // 0.1 ms glitch filter keeps response under 0.3 ms and passes
      // 1 kHz pulses, which last 0.5 ms per level
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            ip_cnt_q[i]  <= 14'h0000;
            ip_filt_q[i] <= 1'b0;
         end else if (in_word0[3+i] == ip_filt_q[i]) begin
            ip_cnt_q[i] <= 14'h0000;
         end else if (ip_cnt_q[i] == 14'(`IFI_IRQ_FILT_CYC - 1)) begin
            ip_filt_q[i] <= in_word0[3+i];
            ip_cnt_q[i]  <= 14'h0000;
         end else begin
            ip_cnt_q[i] <= ip_cnt_q[i] + 14'h0001;
         end
      end

      // mode select per input
      always_comb begin
         irq_event[i] = 1'b0;
         if (active_mask[i] && rise[i]) begin
            if (ifi_mode_t'(mode_q[i]) == IFI_MODE_DIRECT) begin
               irq_event[i] = 1'b1; // immediate, scan-independent
            end else begin
               // 16-bit compare; set value 0 fires on every pulse
               irq_event[i] = cnt_q[i] + 16'h0001 >= setv_q[i];
            end
         end
      end

      // counting mode: count rising edges, restart after each hit
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            cnt_q[i] <= 16'h0000;
         end else if (ifi_mode_t'(mode_q[i]) == IFI_MODE_DIRECT) begin
            cnt_q[i] <= 16'h0000;
         end else if (active_mask[i] && rise[i]) begin
            if (irq_event[i]) begin
               cnt_q[i] <= 16'h0000;
            end else begin
               cnt_q[i] <= cnt_q[i] + 16'h0001;
            end
         end
      end

      // quick-response latch: held until the scan that reads it; a
      // pulse arriving on the scan edge itself is kept
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            quick_q[i] <= 1'b0;
         end else if (active_mask[i] && rise[i]) begin
            quick_q[i] <= 1'b1;
         end else if (scan_start) begin
            quick_q[i] <= 1'b0;
         end
      end

      // sticky status; set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            status_q[i] <= 1'b0;
         end else if (irq_event[i]) begin
            status_q[i] <= 1'b1;
         end else if (wr_clear && reg_wdata[i]) begin
            status_q[i] <= 1'b0;
         end
      end
   end

   // edge history of the filtered interrupt inputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ip_prev_q <= 4'h0;
      end else begin
         ip_prev_q <= ip_filt_q;
      end
   end

   // binary to BCD, clamped to 200
   function automatic logic [15:0] to_bcd(input logic [7:0] v);
      logic [7:0] c;
      logic [3:0] h;
      logic [7:0] r;
      c = (v > `IFI_KNOB_MAX) ? `IFI_KNOB_MAX : v;
      h = (c >= 8'hc8) ? 4'h2 : (c >= 8'h64) ? 4'h1 : 4'h0;
      // widen the hundreds digit first: 2 * 100 does not fit in 7 bits
      r = c - 8'(h) * 8'h64;
      to_bcd = {4'h0, h, 4'(r / 8'h0a), 4'(r % 8'h0a)};
   endfunction

   // knob words refresh only when the knob moves
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         knob0_seen_q <= 8'h00;
         knob1_seen_q <= 8'h00;
         knob0_q      <= 16'h0000;
         knob1_q      <= 16'h0000;
      end else begin
         if (knob0_raw != knob0_seen_q) begin
            knob0_seen_q <= knob0_raw;
            knob0_q      <= to_bcd(knob0_raw);
         end
         if (knob1_raw != knob1_seen_q) begin
            knob1_seen_q <= knob1_raw;
            knob1_q      <= to_bcd(knob1_raw);
         end
      end
   end

   // software-written configuration
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q   <= `IFI_CTRL_RESET;
         mode_q   <= 4'h0;
         enable_q <= 4'h0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `IFI_REG_CTRL:   ctrl_q   <= reg_wdata;
            `IFI_REG_MODE:   mode_q   <= reg_wdata[3:0];
            `IFI_REG_ENABLE: enable_q <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // set values, one word per input
   for (genvar s = 0; s < NIRQ; s++) begin : g_setv
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            setv_q[s] <= 16'h0000;
         end else if (reg_wr && reg_addr == `IFI_REG_SETV0 + 8'(s)) begin
            setv_q[s] <= reg_wdata;
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero.
   // bits not set to interrupt use read as plain inputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         if (reg_addr == `IFI_REG_CTRL)        reg_rdata <= ctrl_q;
         else if (reg_addr == `IFI_REG_MODE)   reg_rdata <= {12'h000, mode_q};
         else if (reg_addr == `IFI_REG_STATUS) reg_rdata <= {12'h000, status_q};
         else if (reg_addr == `IFI_REG_ENABLE) reg_rdata <= {12'h000, enable_q};
         else if (reg_addr == `IFI_REG_QUICK)  reg_rdata <= {12'h000, quick_q};
         else if (reg_addr == `IFI_REG_IN0)    reg_rdata <= {4'h0, filt0_q};
         else if (reg_addr == `IFI_REG_IN1)    reg_rdata <= {4'h0, filt1_q};
         else if (reg_addr >= `IFI_REG_SETV0 && reg_addr < `IFI_REG_SETV0 + 8'h04)
            reg_rdata <= setv_q[2'(reg_addr)];
         else if (reg_addr >= `IFI_REG_CNT0 && reg_addr < `IFI_REG_CNT0 + 8'h04)
            reg_rdata <= cnt_q[2'(reg_addr)];
         else if (reg_addr == `IFI_REG_KNOB0)  reg_rdata <= knob0_q;
         else if (reg_addr == `IFI_REG_KNOB1)  reg_rdata <= knob1_q;
         else reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // level interrupt, registered; the refresh spacing is software's job
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & enable_q);
      end
   end

endmodule

// file: ifi_properties.sv
/* port assertions for ifi_unit.
   assumes a bind from the bench and knobs held at zero through reset. */
`timescale 1ns/1ps
`include "ifi_defs.svh"
module ifi_properties (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // field and register inputs
   input wire logic [11:0] in_word0,
   input wire logic [7:0]  knob0_raw,
   input wire logic [7:0]  knob1_raw,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   // outputs
   input wire logic [15:0] reg_rdata,
   input wire logic        irq
);
   logic [3:0]  en_q, mode_q, rises_q, kage_q;
   logic        big_q, k0_chg_q;
   logic [15:0] setv_q, hi3_q, hi5_q;
   logic [7:0]  k0_p_q, k1_p_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   function automatic logic [15:0] to_bcd(input logic [7:0] v);
      logic [7:0] c;
      c = (v > 8'hc8) ? 8'hc8 : v;
      return {4'h0, 4'(c / 8'h64), 4'(c / 8'h0a % 8'h0a), 4'(c % 8'h0a)};
   endfunction
   // shadow of the settings software wrote
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         {en_q, mode_q, big_q, setv_q} <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            `IFI_REG_CTRL:   big_q  <= reg_wdata[`IFI_CTRL_BIG_BIT];
            `IFI_REG_MODE:   mode_q <= reg_wdata[3:0];
            `IFI_REG_ENABLE: en_q   <= reg_wdata[3:0];
            `IFI_REG_SETV0:  setv_q <= reg_wdata;
            default: ;
         endcase
      end
   end
   // high time of terminals, rises since setup, knob settle age
   always_ff @(posedge clk) begin
      k0_p_q <= knob0_raw;
      k1_p_q <= knob1_raw;
      hi3_q  <= in_word0[3] ? hi3_q + {15'h0, hi3_q != 16'hffff} : 16'h0;
      hi5_q  <= in_word0[5] ? hi5_q + {15'h0, hi5_q != 16'hffff} : 16'h0;
      if (!rst_n) begin
         {rises_q, kage_q, k0_chg_q} <= '0;
      end else begin
         k0_chg_q <= k0_chg_q | (knob0_raw != k0_p_q);
         kage_q   <= (knob0_raw != k0_p_q || knob1_raw != k1_p_q) ? 4'h0
                     : kage_q + {3'h0, kage_q != 4'hf};
         if (reg_wr && reg_addr inside {`IFI_REG_MODE, `IFI_REG_SETV0})
            rises_q <= 4'h0;
         else if (in_word0[3] && hi3_q == 16'h0)
            rises_q <= rises_q + 4'h1;
      end
   end
   a_rdata_idle_zero: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray data");
   a_knob0_bcd_word: assert property (
      $past(reg_rd) && $past(reg_addr) == `IFI_REG_KNOB0 && kage_q > 4'h8
      |-> reg_rdata == to_bcd(k0_chg_q ? knob0_raw : 8'h00))
      else $error("knob zero word wrong");
   a_knob1_in_range: assert property (
      $past(reg_rd) && $past(reg_addr) == `IFI_REG_KNOB1
      |-> reg_rdata <= 16'h0200 && reg_rdata[3:0] < 4'ha)
      else $error("knob one word out of range");
   a_direct_irq_fast: assert property (
      hi5_q == 16'h2706 && !irq && big_q && en_q[2] && !mode_q[2]
      |-> ##[1:25] irq) else $error("direct interrupt late");
   a_small_masks_high: assert property (
      hi5_q == 16'h2706 && !irq && !big_q && en_q == 4'hc
      |-> ##1 (!irq) [*8] ##1 (!irq) [*8]) else $error("masked input fired");
   a_count_defers_irq: assert property (
      hi3_q == 16'h2706 && !irq && en_q == 4'h1 && mode_q[0] &&
      setv_q == 16'h0002 && rises_q[0]
      |-> ##1 (!irq) [*8] ##1 (!irq) [*8]) else $error("count fired early");
   a_count_fires_set: assert property (
      hi3_q == 16'h2706 && !irq && en_q == 4'h1 && mode_q[0] &&
      setv_q == 16'h0002 && !rises_q[0] && rises_q != 4'h0
      |-> ##[1:25] irq) else $error("count interrupt missing");
   a_irq_needs_enable: assert property (
      en_q == 4'h0 |=> !irq) else $error("interrupt while disabled");
   c_direct: cover property (hi5_q == 16'h2706 && big_q);
   c_count: cover property (rises_q == 4'h2 && irq);
   c_knob: cover property ($past(reg_rd) && $past(reg_addr) == `IFI_REG_KNOB1);
endmodule

// file: ifi_field_model.sv
/* field terminals and program scan for the bench.
   assumes one request at a time, waiting on busy between pulses. */
`timescale 1ns/1ps
module ifi_field_model (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // requests from the bench
   input wire logic        pulse_go,
   input wire logic [3:0]  pulse_mask,
   input wire logic [15:0] pulse_hi,
   input wire logic        scan_go,
   // field side
   output logic     [3:0]  term,
   output logic            scan_start,
   output logic            busy
);
   logic [15:0] cnt_q;
   logic        low_q;
   // one pulse, then a quiet gap so filters see the fall; the gap is
   // shorter than a 1 kHz period, traded for run time
   always_ff @(posedge clk) begin
      scan_start <= rst_n && scan_go;
      if (!rst_n) begin
         {term, busy, cnt_q, low_q} <= '0;
      end else if (pulse_go && !busy) begin
         {term, busy, cnt_q, low_q} <= {pulse_mask, 1'b1, pulse_hi, 1'b0};
      end else if (busy && cnt_q != 16'h0) begin
         cnt_q <= cnt_q - 16'h1;
      end else if (busy && !low_q) begin
         {term, cnt_q, low_q} <= {4'h0, 16'h2774, 1'b1};
      end else begin
         busy <= 1'b0;
      end
   end
endmodule

// file: tb_top.sv
/* self-checking bench for ifi_unit.
   assumes the field model drives terminals 3..6 of the first word. */
`timescale 1ns/1ps
`include "ifi_defs.svh"
module tb_top;
   typedef struct packed {
      logic [7:0]  k0, k1;
      logic [15:0] e0, e1;
   } ifi_row_t;
   ifi_row_t    rows [4] = '{'{8'h05, 8'hc7, 16'h0005, 16'h0199},
      '{8'hc8, 8'h0a, 16'h0200, 16'h0010}, '{8'hff, 8'h63, 16'h0200,
      16'h0099}, '{8'h7b, 8'h00, 16'h0123, 16'h0000}};
   logic        clk, rst_n, reg_wr, reg_rd, pulse_go, scan_go, scan_start;
   logic        irq, busy;
   logic [7:0]  knob0_raw, knob1_raw, reg_addr;
   logic [15:0] reg_wdata, reg_rdata, pulse_hi;
   logic [3:0]  term, pulse_mask;
   int          fail_count, total_checks, cycles;
   ifi_unit u_ifi_unit (.clk(clk), .rst_n(rst_n),
      .in_word0({5'h00, term, 3'h0}), .in_word1({8'h00, term}),
      .scan_start(scan_start), .knob0_raw(knob0_raw), .knob1_raw(knob1_raw),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   ifi_field_model u_ifi_field_model (.clk(clk), .rst_n(rst_n),
      .pulse_go(pulse_go), .pulse_mask(pulse_mask), .pulse_hi(pulse_hi),
      .scan_go(scan_go), .term(term), .scan_start(scan_start), .busy(busy));
   task automatic check(input string w, input logic [15:0] e, g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rc(input logic [7:0] a, input logic [15:0] e, string w);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(w, e, reg_rdata);
   endtask
   task automatic pulse(input logic [3:0] m, input logic [15:0] h);
      @(posedge clk);
      {pulse_go, pulse_mask, pulse_hi} <= {1'b1, m, h};
      @(posedge clk);
      pulse_go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 32'h000186a0) begin
         check("cycle limit", 16'h0000, 16'h0001);
         complete_run();
      end
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, knob0_raw} = '0;
      {knob1_raw, pulse_go, pulse_mask, pulse_hi, scan_go} = '0;
      {fail_count, total_checks, cycles} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rc(`IFI_REG_CTRL, 16'h0000, "ctrl");
      rc(`IFI_REG_KNOB0, 16'h0000, "knob0");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {knob0_raw, knob1_raw} <= {rows[i].k0, rows[i].k1};
         repeat (10) @(posedge clk);
         rc(`IFI_REG_KNOB0, rows[i].e0, "knob0");
         rc(`IFI_REG_KNOB1, rows[i].e1, "knob1");
      end
      wr(`IFI_REG_KNOB0, 16'h0077);
      rc(`IFI_REG_KNOB0, 16'h0123, "knob0 ro");
      rc(8'h20, 16'h0000, "unmapped");
      $display("test knobs done");
      wr(`IFI_REG_ENABLE, 16'h000c);
      // mid-pulse, the slow word filters must still hold their old value
      fork
         pulse(4'hf, 16'h4e84);
         begin
            repeat (15000) @(posedge clk);
            rc(`IFI_REG_IN0, 16'h0000, "in0 slow");
            rc(`IFI_REG_IN1, 16'h0000, "in1 slow");
         end
      join
      rc(`IFI_REG_STATUS, 16'h0003, "status small");
      check("irq masked", 16'h0000, {15'h0, irq});
      rc(`IFI_REG_QUICK, 16'h0003, "quick");
      @(posedge clk);
      scan_go <= 1'b1; // lone scan, no refresh burst
      @(posedge clk);
      scan_go <= 1'b0;
      repeat (3) @(posedge clk);
      rc(`IFI_REG_QUICK, 16'h0000, "quick scan");
      wr(`IFI_REG_ENABLE, 16'h000f);
      repeat (3) @(posedge clk);
      check("irq on", 16'h0001, {15'h0, irq});
      wr(`IFI_REG_CLEAR, 16'h000f);
      repeat (3) @(posedge clk);
      check("irq off", 16'h0000, {15'h0, irq});
      $display("test direct done");
      wr(`IFI_REG_CTRL, 16'h0010);
      wr(`IFI_REG_MODE, 16'h0001);
      wr(`IFI_REG_SETV0, 16'h0002);
      wr(`IFI_REG_ENABLE, 16'h0004);
      pulse(4'h5, 16'h2774);
      rc(`IFI_REG_STATUS, 16'h0004, "status big");
      wr(`IFI_REG_CLEAR, 16'h000f);
      wr(`IFI_REG_ENABLE, 16'h0001);
      pulse(4'h1, 16'h2774);
      rc(`IFI_REG_STATUS, 16'h0001, "count hit");
      wr(`IFI_REG_CLEAR, 16'h000f);
      pulse(4'h1, 16'h2774);
      rc(`IFI_REG_STATUS, 16'h0000, "count restart");
      rc(`IFI_REG_CNT0, 16'h0001, "count value");
      $display("test count done");
      complete_run();
   end
endmodule
bind ifi_unit ifi_properties u_ifi_properties (.clk(clk), .rst_n(rst_n),
   .in_word0(in_word0), .knob0_raw(knob0_raw), .knob1_raw(knob1_raw),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
